// File: common/prog_read_pkg.sv
// Shared constants and carriers for the program memory read path
package prog_read_pkg;
    localparam int          PTR_W          = 16;
    localparam int          PROG_SEL_BIT   = 15;
    localparam int          BYTE_W         = 8;
    localparam int          WORD_W         = 14;
    localparam int          SIZE_W         = 14;
    localparam int          PROG_WORDS_DEF = 4096;
    localparam int          PROTECT_BIT    = 0;
    localparam int          BOOT_DIS_BIT   = 3;
    localparam logic [7:0]  ADR_CFG        = 8'h00;
    localparam logic [7:0]  ADR_BOOT_CTL   = 8'h04;
    localparam logic [7:0]  ADR_BOOT_STAT  = 8'h08;
    localparam logic [7:0]  ADR_PROG_ADDR  = 8'h0C;
    localparam logic [7:0]  ADR_PROG_DATA  = 8'h10;
    localparam logic [13:0] CFG_RESET      = 14'h3FFF;
    localparam logic [3:0]  BOOT_CTL_RESET = 4'hF;
    localparam logic [2:0]  SEL_512        = 3'h7;
    localparam logic [2:0]  SEL_1K         = 3'h6;
    localparam logic [2:0]  SEL_2K         = 3'h5;
    localparam logic [2:0]  SEL_4K         = 3'h4;
    localparam logic [13:0] WORDS_512      = 14'h0200;
    localparam logic [13:0] WORDS_1K       = 14'h0400;
    localparam logic [13:0] WORDS_2K       = 14'h0800;
    localparam logic [13:0] WORDS_4K       = 14'h1000;
    localparam logic [13:0] WORDS_8K       = 14'h2000;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [PTR_W-1:0]  ptr;
        logic [BYTE_W-1:0] wdata;
    } core_req_t;

    typedef struct packed {
        logic              ack;
        logic [BYTE_W-1:0] rdata;
    } core_rsp_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [PTR_W-1:0]  addr;
        logic [BYTE_W-1:0] wdata;
    } dm_req_t;
endpackage : prog_read_pkg

// File: hdl/prog_mem_reader.sv
// Indirect program memory read path with boot block and protection regs
`timescale 1ns/1ps
`default_nettype none
module prog_mem_reader
    import prog_read_pkg::*;
#(
    parameter int PROG_WORDS = PROG_WORDS_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire core_req_t   core_req_i,
    output core_rsp_t        core_rsp_o,
    output dm_req_t          dm_req_o,
    input  wire logic [7:0]  dm_rdata_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    localparam int          AW         = $clog2(PROG_WORDS);
    localparam logic [13:0] HALF_WORDS = 14'(PROG_WORDS / 2);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_FETCH,
        ST_PROG_ACK
    } rd_state_t;

    rd_state_t         state_q, state_d;
    logic [7:0]        rdata_q, rdata_d;
    logic [13:0]       cfg_q, cfg_d;
    logic [3:0]        boot_ctl_q, boot_ctl_d;
    logic [AW-1:0]     paddr_q, paddr_d;
    logic              ack_q, ack_d;
    logic [31:0]       dat_q, dat_d;
    logic              prog_sel;
    logic              mem_we;
    logic [WORD_W-1:0] word_a;
    logic [WORD_W-1:0] word_b;
    logic [13:0]       boot_raw;
    logic [13:0]       boot_size;
    logic [13:0]       boot_last;
    logic              wb_req;
    logic              wb_wr_now;
    logic              protect_on;

    assign prog_sel   = core_req_i.ptr[PROG_SEL_BIT];
    assign protect_on = ~cfg_q[PROTECT_BIT];
    assign wb_req     = wb_cyc_i & wb_stb_i;
    // Writes land on the edge that sees ack high, as the master expects
    assign wb_wr_now  = wb_req & wb_we_i & ack_q;
    assign mem_we     = wb_wr_now & (wb_adr_i == ADR_PROG_DATA)
                        & wb_sel_i[0] & wb_sel_i[1];

    // Pointer bits above the array depth are ignored, so addresses alias
    prog_word_store #(
        .WIDTH (WORD_W),
        .DEPTH (PROG_WORDS)
    ) u_store (
        .clk_i       (clk_i),
        .wr_en_i     (mem_we),
        .wr_addr_i   (paddr_q),
        .wr_data_i   (wb_dat_i[WORD_W-1:0]),
        .rd_a_addr_i (core_req_i.ptr[AW-1:0]),
        .rd_a_data_o (word_a),
        .rd_b_addr_i (paddr_q),
        .rd_b_data_o (word_b)
    );

    always_comb begin
        case (boot_ctl_q[2:0])
            SEL_512: boot_raw = WORDS_512;
            SEL_1K:  boot_raw = WORDS_1K;
            SEL_2K:  boot_raw = WORDS_2K;
            SEL_4K:  boot_raw = WORDS_4K;
            default: boot_raw = WORDS_8K;
        endcase
        if (boot_ctl_q[BOOT_DIS_BIT]) begin
            boot_size = 14'h0000;
        end else if (boot_raw > HALF_WORDS) begin
            boot_size = HALF_WORDS;
        end else begin
            boot_size = boot_raw;
        end
        boot_last = (boot_size == 14'h0000) ? 14'h0000
                                            : boot_size - 14'h0001;
    end

    // Data memory is assumed to answer reads combinationally
    always_comb begin
        dm_req_o       = '0;
        dm_req_o.addr  = core_req_i.ptr;
        dm_req_o.wdata = core_req_i.wdata;
        dm_req_o.write = core_req_i.write;
        if (state_q == ST_IDLE && core_req_i.valid && !prog_sel) begin
            dm_req_o.valid = 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        case (state_q)
            ST_IDLE: begin
                if (core_req_i.valid) begin
                    if (!prog_sel) begin
                        rdata_d = core_req_i.write ? rdata_q : dm_rdata_i;
                        state_d = ST_DATA;
                    end else if (core_req_i.write) begin
                        state_d = ST_DATA;
                    end else begin
                        state_d = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                rdata_d = word_a[BYTE_W-1:0];
                state_d = ST_PROG_ACK;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    assign core_rsp_o.ack   = (state_q == ST_DATA) | (state_q == ST_PROG_ACK);
    assign core_rsp_o.rdata = rdata_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            rdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb begin
        cfg_d      = cfg_q;
        boot_ctl_d = boot_ctl_q;
        paddr_d    = paddr_q;
        ack_d      = wb_req & ~ack_q;
        dat_d      = 32'h0000_0000;
        if (wb_wr_now && wb_sel_i[0]) begin
            if (wb_adr_i == ADR_CFG) begin
                // Only the protect bit is programmable; the rest read one
                cfg_d[PROTECT_BIT] = wb_dat_i[PROTECT_BIT];
            end else if (wb_adr_i == ADR_BOOT_CTL) begin
                boot_ctl_d = wb_dat_i[3:0];
            end else if (wb_adr_i == ADR_PROG_ADDR) begin
                paddr_d[7:0] = wb_dat_i[7:0];
            end
        end
        if (wb_wr_now && wb_sel_i[1] && wb_adr_i == ADR_PROG_ADDR) begin
            paddr_d[AW-1:8] = wb_dat_i[AW-1:8];
        end
        if (wb_req && !ack_q && !wb_we_i) begin
            if (wb_adr_i == ADR_CFG) begin
                dat_d[13:0] = cfg_q;
            end else if (wb_adr_i == ADR_BOOT_CTL) begin
                dat_d[3:0] = boot_ctl_q;
            end else if (wb_adr_i == ADR_BOOT_STAT) begin
                dat_d = {2'b00, boot_last, 2'b00, boot_size};
            end else if (wb_adr_i == ADR_PROG_ADDR) begin
                dat_d[AW-1:0] = paddr_q;
            end else if (wb_adr_i == ADR_PROG_DATA && !protect_on) begin
                dat_d[WORD_W-1:0] = word_b;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q      <= CFG_RESET;
            boot_ctl_q <= BOOT_CTL_RESET;
            paddr_q    <= '0;
            ack_q      <= 1'b0;
            dat_q      <= 32'h0000_0000;
        end else begin
            cfg_q      <= cfg_d;
            boot_ctl_q <= boot_ctl_d;
            paddr_q    <= paddr_d;
            ack_q      <= ack_d;
            dat_q      <= dat_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_prog_no_dm: assert property (
        state_q == ST_IDLE && core_req_i.valid && prog_sel |-> !dm_req_o.valid)
        else $error("program access leaked to data memory");
    a_data_to_dm: assert property (
        state_q == ST_IDLE && core_req_i.valid && !prog_sel
        |-> dm_req_o.valid ##1 core_rsp_o.ack)
        else $error("data access not routed or not acked in one cycle");
    a_low_byte_read: assert property (
        state_q == ST_FETCH |=> core_rsp_o.ack
        && core_rsp_o.rdata == $past(word_a[7:0]))
        else $error("program read did not return low byte");
    a_prog_wr_ignored: assert property (
        state_q == ST_IDLE && core_req_i.valid && prog_sel
        && core_req_i.write |-> !mem_we ##1 (core_rsp_o.ack && !mem_we))
        else $error("indirect write touched program memory");
    a_extra_cycle: assert property (
        state_q == ST_IDLE && core_req_i.valid && prog_sel
        && !core_req_i.write |-> !core_rsp_o.ack ##1 !core_rsp_o.ack
        ##1 core_rsp_o.ack)
        else $error("program read not exactly one cycle longer");
    a_boot_disabled: assert property (
        boot_ctl_q[BOOT_DIS_BIT] |-> boot_size == 14'h0000)
        else $error("disabled boot block has nonzero size");
    a_boot_clamp: assert property (
        !boot_ctl_q[BOOT_DIS_BIT] && boot_raw >= HALF_WORDS
        |-> boot_size == HALF_WORDS)
        else $error("boot block not clamped to half memory");
    a_protect_read: assert property (
        wb_req && !ack_q && !wb_we_i && wb_adr_i == ADR_PROG_DATA
        && !cfg_q[PROTECT_BIT] |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("protected flash word was readable");
    a_word_addr: assert property (
        state_q == ST_IDLE && core_req_i.valid && prog_sel
        && !core_req_i.write && !mem_we
        |=> word_a == u_store.mem[$past(core_req_i.ptr[AW-1:0])])
        else $error("program word fetched from wrong address");
endmodule : prog_mem_reader
`default_nettype wire

// File: hdl/prog_word_store.sv
// Program word array with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module prog_word_store #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4096,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk_i,
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic [AW-1:0]    rd_a_addr_i,
    output logic      [WIDTH-1:0] rd_a_data_o,
    input  wire logic [AW-1:0]    rd_b_addr_i,
    output logic      [WIDTH-1:0] rd_b_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_a_data_o <= mem[rd_a_addr_i];
        rd_b_data_o <= mem[rd_b_addr_i];
    end
endmodule : prog_word_store
`default_nettype wire

// File: testbench/data_mem_model.sv
// Combinational data memory standing behind the indirect data path
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
    import prog_read_pkg::*;
(
    input  wire dm_req_t    dm_req_i,
    output logic      [7:0] rdata_o
);
    // Unselected cycles show the inverse so stale data cannot match
    always_comb begin
        rdata_o = dm_req_i.addr[7:0] ^ dm_req_i.addr[15:8] ^ 8'h5A;
        if (!dm_req_i.valid) rdata_o = ~rdata_o;
    end
endmodule : data_mem_model
`default_nettype wire

// File: testbench/prog_mem_reader_tb.sv
// Self-checking bench for the program memory read path
`timescale 1ns/1ps
`default_nettype none
module prog_mem_reader_tb;
    import prog_read_pkg::*;
    localparam int PW = 4096;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i, dm_rdata_i, last_rd, core_q[$];
    logic [3:0]  wb_sel_i, sel_use;
    logic [31:0] wb_dat_i, wb_dat_o, wb_q[$];
    core_req_t   core_req_i;
    core_rsp_t   core_rsp_o;
    dm_req_t     dm_req_o;
    int          mismatches, check_count;
    logic [11:0] pa[8];
    logic [13:0] pw[8];

    prog_mem_reader #(.PROG_WORDS(PW)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .core_req_i(core_req_i), .core_rsp_o(core_rsp_o),
        .dm_req_o(dm_req_o), .dm_rdata_i(dm_rdata_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o));
    data_mem_model dmem (.dm_req_i(dm_req_o), .rdata_o(dm_rdata_i));

    function automatic logic [7:0] dm_byte(logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : dm_byte

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat,
                      logic [31:0] exp);
        int n;
        wb_q.push_back(we ? 32'h0 : exp);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {adr, dat, sel_use};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 20) check("wb ack wait", 0, 1);
        if (n == 20) give_verdict();
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb

    task automatic core(logic wr, logic [15:0] ptr, logic [7:0] wd,
                        logic [7:0] exp);
        int n;
        if (!wr) last_rd = exp;
        core_q.push_back(last_rd);
        core_req_i <= '{1'b1, wr, ptr, wd};
        for (n = 1; n < 20; n++) begin
            @(posedge clk_i);
            if (n == 1) check("dm valid", !ptr[15], dm_req_o.valid);
            if (n == 1 && !ptr[15]) begin
                check("dm write", wr, dm_req_o.write);
                check("dm addr", ptr, dm_req_o.addr);
                if (wr) check("dm wdata", wd, dm_req_o.wdata);
            end
            if (core_rsp_o.ack === 1'b1) break;
        end
        check("core latency", (ptr[15] && !wr) ? 3 : 2, n);
        if (n == 20) give_verdict();
        core_req_i.valid <= 1'b0;
        @(posedge clk_i);
    endtask : core

    // Results are matched in arrival order against the noted values
    always @(posedge clk_i) begin
        if (core_rsp_o.ack === 1'b1 && core_q.size() > 0)
            check("core rdata", core_q.pop_front(), core_rsp_o.rdata);
        if (wb_ack_o === 1'b1 && wb_q.size() > 0)
            check("wb dat", wb_q.pop_front(), wb_dat_o);
    end

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin : main
        int i;
        logic [3:0] c;
        logic [13:0] sz;
        logic [15:0] p;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} = {4'h8, 8'h00};
        {wb_sel_i, wb_dat_i, core_req_i} = '0;
        sel_use = 4'hF;
        {mismatches, check_count, last_rd} = '0;
        void'($urandom(32'hA4D0));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, ADR_CFG, 0, {18'h0, CFG_RESET});
        wb(0, ADR_BOOT_STAT, 0, 0);
        for (i = 0; i < 8; i++) begin
            pa[i] = 12'(i * 509 + $urandom_range(0, 7));
            pw[i] = 14'($urandom);
            wb(1, ADR_PROG_ADDR, {20'h0, pa[i]}, 0);
            wb(1, ADR_PROG_DATA, {18'h0, pw[i]}, 0);
            wb(0, ADR_PROG_DATA, 0, {18'h0, pw[i]});
        end
        for (i = 0; i < 8; i++) begin
            p = {1'b1, 3'($urandom), pa[i]};
            core(0, p, 0, pw[i][7:0]);
            core(1, p, 8'($urandom), 0);
            core(0, p, 0, pw[i][7:0]);
            p = {1'b0, 15'($urandom)};
            core(0, p, 0, dm_byte(p));
            core(1, p, 8'($urandom), 0);
        end
        for (i = 0; i < 16; i++) begin
            c = 4'(i);
            sz = (c[2:0] == SEL_512) ? WORDS_512 : (c[2:0] == SEL_1K) ?
                 WORDS_1K : (c[2:0] == SEL_2K) ? WORDS_2K :
                 (c[2:0] == SEL_4K) ? WORDS_4K : WORDS_8K;
            if (sz > 14'(PW / 2)) sz = 14'(PW / 2);
            if (c[3]) sz = 14'h0;
            wb(1, ADR_BOOT_CTL, {28'h0, c}, 0);
            wb(0, ADR_BOOT_CTL, 0, {28'h0, c});
            wb(0, ADR_BOOT_STAT, 0, {2'h0, sz - 14'(sz != 0), 2'h0, sz});
        end
        wb(1, ADR_CFG, 0, 0);
        wb(0, ADR_CFG, 0, 32'h3FFE);
        wb(0, ADR_PROG_DATA, 0, 0);
        wb(1, ADR_CFG, 32'h1, 0);
        wb(0, ADR_PROG_DATA, 0, {18'h0, pw[7]});
        // Partial byte enables must not store a program word
        sel_use = 4'h1;
        wb(1, ADR_PROG_DATA, {18'h0, ~pw[7]}, 0);
        sel_use = 4'hF;
        wb(0, ADR_PROG_DATA, 0, {18'h0, pw[7]});
        sel_use = 4'h2;
        wb(1, ADR_PROG_ADDR, 32'h0000_0FFF, 0);
        sel_use = 4'hF;
        wb(0, ADR_PROG_ADDR, 0, {20'h0, 4'hF, pa[7][7:0]});
        wb(1, 8'h14, 32'hFFFF_FFFF, 0);
        wb(0, 8'h14, 0, 0);
        wb(1, ADR_CFG, 0, 0);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, ADR_CFG, 0, {18'h0, CFG_RESET});
        give_verdict();
    end
endmodule : prog_mem_reader_tb
`default_nettype wire
